// file: core/ccr_pkg.sv
// Constants for the configuration, identity and current offset registers.
// Assumes a command-code addressed register port driven by a bus engine.
package ccr_pkg;
   localparam logic [7:0]  CMD_APP_CODE  = 8'h46;
   localparam logic [7:0]  CMD_CFG_REV   = 8'h47;
   localparam logic [7:0]  CMD_OC_WARN   = 8'h4A;
   localparam logic [7:0]  CMD_OFS_A     = 8'h4C;
   localparam logic [7:0]  CMD_OFS_B     = 8'h4D;
   localparam logic [7:0]  CMD_OFS_SPARE = 8'h4E;
   localparam int          APP_REV_HI    = 15;
   localparam int          APP_REV_LO    = 12;
   localparam int          DIE_REV_HI    = 11;
   localparam int          DIE_REV_LO    = 8;
   localparam int          FW_REV_HI     = 7;
   localparam int          FW_REV_LO     = 0;
   localparam logic [3:0]  APP_REV_ENG   = 4'hE;
   localparam logic [3:0]  APP_REV_PROD  = 4'h0;
   localparam int          OC_WIDTH      = 10;
   localparam int          OFS_WIDTH     = 5;
   localparam int          OFS_A_MASK_W  = 15;
   localparam int          OFS_B_MASK_W  = 10;
   localparam int          OC_STATUS_BIT = 5;
   localparam logic [15:0] OC_WARN_MASK  = 16'h03FF;
   localparam logic [15:0] OFS_A_MASK    = 16'h7FFF;
   localparam logic [15:0] OFS_B_MASK    = 16'h03FF;
   localparam logic [15:0] APP_CODE_RST  = 16'h0000;
   localparam logic [15:0] CFG_REV_RST   = 16'hE000;
   localparam logic [15:0] OC_WARN_RST   = 16'h0000;
   localparam logic [15:0] OFS_RST       = 16'h0000;
endpackage

// file: core/ccr_ofs_add.sv
// Adds one signed five-bit balance offset to a sensed phase current.
// Assumes the sensed current is an unsigned code; the result saturates.
`timescale 1ns/100ps
module ccr_ofs_add
   import ccr_pkg::*;
#(
   parameter int CUR_W = 12
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic [OFS_WIDTH-1:0] ofs_i,
   input  wire logic [CUR_W-1:0]     cur_i,
   output logic      [CUR_W-1:0]     cur_o
);
   logic signed [CUR_W+1:0] sum;
   logic        [CUR_W-1:0] cur_d;

   // The offset is sign extended before the sum.
   always_comb begin
      sum = $signed({2'b00, cur_i})
          + {{(CUR_W+2-OFS_WIDTH){ofs_i[OFS_WIDTH-1]}}, ofs_i};
      if (sum < 0) begin
         cur_d = '0;
      end else if (sum[CUR_W]) begin
         cur_d = '1;
      end else begin
         cur_d = sum[CUR_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cur_o <= '0;
      end else begin
         cur_o <= cur_d;
      end
   end
endmodule

// file: core/ccr_regs.sv
// Configuration code, revision, current warning and phase offset registers.
// Assumes a bus engine presents a command code with one-cycle write and
// read strobes, and that the sensed currents are synchronous to clk_i.
//
// Behaviour
// - Sixteen-bit read/write application configuration code register.
// - Revision bits 15:12 hold build revision; E engineering, 0 production.
// - Revision bits 11:8 hold die revision counting up from zero.
// - Revision low byte holds the firmware configuration revision.
// - Reserved bits ignore writes and read zero, spare register included.
// - Sensed output current above ten-bit threshold sets status bit five.
// - Threshold scale is one ampere per LSB, or two when selected.
// - First offset register: phases four, three, two in 5-bit fields.
// - Second offset register: phases six and five; bits 15:10 reserved.
// - Each signed offset is applied to its phase current in balancing.
`timescale 1ns/100ps
module ccr_regs
   import ccr_pkg::*;
#(
   parameter int CUR_W = 12
) (
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   input  wire logic [7:0]         cmd_i,
   input  wire logic               wr_i,
   input  wire logic               rd_i,
   input  wire logic [15:0]        wdata_i,
   output logic      [15:0]        rdata_o,
   output logic                    rvalid_o,
   output logic                    hit_o,
   input  wire logic               current_scale_select_i,
   input  wire logic [CUR_W-1:0]   iout_amps_i,
   input  wire logic [CUR_W-1:0]   phase_cur_i [6],
   output logic      [CUR_W-1:0]   phase_cur_o [6],
   output logic                    oc_warn_o,
   output logic      [7:0]         output_current_status_o
);
   logic [15:0]            application_config_code_q;
   logic [15:0]            configuration_revision_q;
   logic [OC_WIDTH-1:0]    oc_thresh_q;
   logic [OFS_A_MASK_W-1:0] ofs_a_q;
   logic [OFS_B_MASK_W-1:0] ofs_b_q;
   logic                   oc_warn_q;
   logic [CUR_W:0]         thresh_amps;
   logic [OFS_WIDTH-1:0]   ofs_field [6];
   logic [15:0]            rdata_d;
   logic                   hit;

   function automatic logic known_cmd(input logic [7:0] c);
      return c == CMD_APP_CODE || c == CMD_CFG_REV || c == CMD_OC_WARN ||
             c == CMD_OFS_A || c == CMD_OFS_B || c == CMD_OFS_SPARE;
   endfunction

   assign hit   = known_cmd(cmd_i);
   assign hit_o = hit;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         application_config_code_q <= APP_CODE_RST;
      end else if (wr_i && cmd_i == CMD_APP_CODE) begin
         application_config_code_q <= wdata_i;
      end
   end

   // Build, die and firmware revisions share one word.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         configuration_revision_q <= CFG_REV_RST;
      end else if (wr_i && cmd_i == CMD_CFG_REV) begin
         configuration_revision_q <= wdata_i;
      end
   end

   // Only the threshold field is stored, so bits 15:10 stay zero.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         oc_thresh_q <= OC_WARN_RST[OC_WIDTH-1:0];
      end else if (wr_i && cmd_i == CMD_OC_WARN) begin
         oc_thresh_q <= wdata_i[OC_WIDTH-1:0];
      end
   end

   // The spare register has no storage at all.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ofs_a_q <= OFS_RST[OFS_A_MASK_W-1:0];
         ofs_b_q <= OFS_RST[OFS_B_MASK_W-1:0];
      end else if (wr_i && cmd_i == CMD_OFS_A) begin
         ofs_a_q <= wdata_i[OFS_A_MASK_W-1:0];
      end else if (wr_i && cmd_i == CMD_OFS_B) begin
         ofs_b_q <= wdata_i[OFS_B_MASK_W-1:0];
      end
   end

   // Scale doubles the threshold in amperes when selected.
   assign thresh_amps = current_scale_select_i
                      ? (CUR_W+1)'({oc_thresh_q, 1'b0})
                      : (CUR_W+1)'(oc_thresh_q);

   // Warning is a level that follows the comparison.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         oc_warn_q <= 1'b0;
      end else begin
         oc_warn_q <= {1'b0, iout_amps_i} > thresh_amps;
      end
   end

   assign oc_warn_o = oc_warn_q;
   always_comb begin
      output_current_status_o = 8'h00;
      output_current_status_o[OC_STATUS_BIT] = oc_warn_q;
   end

   // Phase one carries no offset field.
   assign ofs_field[0] = '0;
   assign ofs_field[1] = ofs_a_q[4:0];
   assign ofs_field[2] = ofs_a_q[9:5];
   assign ofs_field[3] = ofs_a_q[14:10];
   assign ofs_field[4] = ofs_b_q[4:0];
   assign ofs_field[5] = ofs_b_q[9:5];

   for (genvar p = 0; p < 6; p++) begin : g_ph
      ccr_ofs_add #(
         .CUR_W (CUR_W)
      ) u_add (
         .clk_i   (clk_i),
         .rst_n_i (rst_n_i),
         .ofs_i   (ofs_field[p]),
         .cur_i   (phase_cur_i[p]),
         .cur_o   (phase_cur_o[p])
      );
   end

   always_comb begin
      unique case (cmd_i)
         CMD_APP_CODE: rdata_d = application_config_code_q;
         CMD_CFG_REV:  rdata_d = configuration_revision_q;
         CMD_OC_WARN:  rdata_d = 16'(oc_thresh_q);
         CMD_OFS_A:    rdata_d = 16'(ofs_a_q);
         CMD_OFS_B:    rdata_d = 16'(ofs_b_q);
         default:      rdata_d = 16'h0000;
      endcase
   end

   // Read data is registered; an unknown command reads zero.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_o  <= 16'h0000;
         rvalid_o <= 1'b0;
      end else begin
         rdata_o  <= rd_i ? rdata_d : rdata_o;
         rvalid_o <= rd_i;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   code_write_a: assert property (
      wr_i && cmd_i == CMD_APP_CODE |=>
      application_config_code_q == $past(wdata_i))
      else $error("config code not stored");
   rev_read_a: assert property (
      rd_i && cmd_i == CMD_CFG_REV |=>
      rdata_o == $past(configuration_revision_q))
      else $error("revision readback mismatch");
   rev_fields_a: assert property (
      wr_i && cmd_i == CMD_CFG_REV |=>
      configuration_revision_q[APP_REV_HI:APP_REV_LO]
      == $past(wdata_i[15:12]))
      else $error("build revision not stored");
   die_rev_a: assert property (
      wr_i && cmd_i == CMD_CFG_REV |=>
      configuration_revision_q[DIE_REV_HI:DIE_REV_LO]
      == $past(wdata_i[11:8]))
      else $error("die revision not stored");
   fw_rev_a: assert property (
      wr_i && cmd_i == CMD_CFG_REV |=>
      configuration_revision_q[FW_REV_HI:FW_REV_LO] == $past(wdata_i[7:0]))
      else $error("firmware revision not stored");
   rsvd_zero_a: assert property (
      rd_i && (cmd_i == CMD_OFS_SPARE || cmd_i == CMD_OC_WARN) |=>
      (rdata_o & ~($past(cmd_i) == CMD_OC_WARN ? OC_WARN_MASK : 16'h0000))
      == 16'h0000)
      else $error("reserved bits read nonzero");
   // Offset words keep their reserved top bits at zero on every read.
   ofs_rsvd_a: assert property (
      rd_i && (cmd_i == CMD_OFS_A || cmd_i == CMD_OFS_B) |=>
      rdata_o[15] == 1'b0
      && ($past(cmd_i) != CMD_OFS_B || rdata_o[15:10] == 6'h00))
      else $error("offset reserved bits read nonzero");
   // A write to the spare code must not disturb the live offsets.
   spare_keep_a: assert property (
      wr_i && cmd_i == CMD_OFS_SPARE |=>
      $stable(ofs_a_q) && $stable(ofs_b_q))
      else $error("spare write changed offsets");
   // The first cycle after reset is not checked, since $past(rst_n_i) is still low.
   oc_flag_a: assert property (
      $past(rst_n_i) |->
      output_current_status_o[OC_STATUS_BIT]
      == ($past({1'b0, iout_amps_i}) > $past(thresh_amps)))
      else $error("warning bit does not follow threshold");
   scale_a: assert property (
      current_scale_select_i |-> thresh_amps == (CUR_W+1)'(oc_thresh_q) * 2)
      else $error("threshold scale wrong");
   ofs_a_fld_a: assert property (
      wr_i && cmd_i == CMD_OFS_A |=> ofs_field[3] == $past(wdata_i[14:10])
      && ofs_field[1] == $past(wdata_i[4:0]))
      else $error("first offset fields misplaced");
   ofs_b_fld_a: assert property (
      wr_i && cmd_i == CMD_OFS_B |=> ofs_field[5] == $past(wdata_i[9:5])
      && ofs_b_q == $past(wdata_i[9:0]))
      else $error("second offset fields misplaced");
   ph_ref_a: assert property (
      1'b1 |=> phase_cur_o[0] == $past(phase_cur_i[0]))
      else $error("reference phase altered");
   ph_bias_a: assert property (
      ofs_field[1] == 5'h01 && phase_cur_i[1] < (CUR_W)'(100)
      && $stable(ofs_field[1])
      |=> phase_cur_o[1] == $past(phase_cur_i[1]) + 1'b1)
      else $error("offset not applied");

   warn_seen_c: cover property (oc_warn_q && current_scale_select_i);
   neg_ofs_c:   cover property (ofs_field[2][OFS_WIDTH-1] && rvalid_o);
   rev_rd_c:    cover property (rd_i && cmd_i == CMD_CFG_REV ##1 rvalid_o);
   spare_wr_c:  cover property (wr_i && cmd_i == CMD_OFS_SPARE);
endmodule

// file: bench/ccr_host_model.sv
// Host side of the command port: one-word writes and reads.
// Assumes the register block samples strobes on the rising clock edge.
`timescale 1ns/100ps
module ccr_host_model (
   input  wire logic        clk_i,
   output logic      [7:0]  cmd_o,
   output logic             wr_o,
   output logic             rd_o,
   output logic      [15:0] wdata_o,
   input  wire logic [15:0] rdata_i,
   input  wire logic        rvalid_i
);
   initial begin
      cmd_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 16'h0000;
   end
   // Offset code from current, sense gain and sense resistor.
   function automatic logic [4:0] ofs_code(input int i, input int k,
                                           input int r);
      return 5'((512 * i * k * r) / 1600);
   endfunction
   task automatic put(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk_i);
      cmd_o <= c;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      // Released data is inverted so a stale word cannot pass as valid.
      wdata_o <= ~d;
   endtask
   task automatic get(input logic [7:0] c, output logic [15:0] d,
                      output logic v);
      @(posedge clk_i);
      cmd_o <= c;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      #1;
      d = rdata_i;
      v = rvalid_i;
   endtask
endmodule

// file: bench/tb_ccr_regs.sv
// Self-checking bench for the register block, driven by the host model.
// Assumes a 20 MHz clock and a synchronous active-low reset.
`timescale 1ns/100ps
module tb_ccr_regs;
   import ccr_pkg::*;
   localparam logic [7:0]  CMDS [6] = '{CMD_APP_CODE, CMD_CFG_REV,
      CMD_OC_WARN, CMD_OFS_A, CMD_OFS_B, CMD_OFS_SPARE};
   localparam logic [15:0] MSKS [6] = '{16'hFFFF, 16'hFFFF,
      OC_WARN_MASK, OFS_A_MASK, OFS_B_MASK, 16'h0000};
   logic        clk, rst_n, wr, rd, rvalid, scale, warn, v, hit;
   logic [7:0]  cmd, stat;
   logic [15:0] wdata, rdata, w, oa, ob;
   logic [11:0] iout, pin [6], pout [6];
   logic [4:0]  of [6];
   int          bad_count, compares, seed;
   ccr_host_model host (.clk_i(clk), .cmd_o(cmd), .wr_o(wr), .rd_o(rd),
      .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
   ccr_regs #(.CUR_W(12)) dut (.clk_i(clk), .rst_n_i(rst_n), .cmd_i(cmd),
      .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata),
      .rvalid_o(rvalid), .hit_o(hit), .current_scale_select_i(scale),
      .iout_amps_i(iout), .phase_cur_i(pin), .phase_cur_o(pout),
      .oc_warn_o(warn), .output_current_status_o(stat));
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdchk(input logic [7:0] c, input logic [15:0] e,
                        input string n);
      host.get(c, w, v);
      chk("rvalid", 16'h0001, {15'h0000, v});
      chk(n, e, w);
   endtask
   // Expected phase output: signed offset added, result held in range.
   function automatic logic [11:0] ph(input logic [11:0] c,
                                      input logic [4:0] o);
      int s;
      s = int'(c) + int'($signed(o));
      return (s < 0) ? 12'h000 : (s > 4095) ? 12'hFFF : 12'(s);
   endfunction
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (4000) @(posedge clk);
      bad_count++;
      close_out();
   end
   initial begin
      seed = 71;
      rst_n = 1'b0;
      scale = 1'b0;
      iout = 12'h000;
      foreach (pin[k]) pin[k] = 12'h000;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(CMD_CFG_REV, CFG_REV_RST, "rev_reset");
      rdchk(CMD_APP_CODE, APP_CODE_RST, "code_reset");
      host.put(CMD_CFG_REV, {APP_REV_PROD, 4'h1, 8'hA5});
      rdchk(CMD_CFG_REV, 16'h01A5, "rev_fields");
      $display("test reset_and_revision done");
      for (int r = 0; r < 4; r++) begin
         for (int k = 0; k < 6; k++) begin
            oa = (r == 0) ? 16'hFFFF : 16'($random(seed));
            host.put(CMDS[k], oa);
            rdchk(CMDS[k], oa & MSKS[k], "reg_word");
            chk("hit", 16'h0001, {15'h0000, hit});
         end
      end
      host.put(8'h50, 16'hFFFF);
      rdchk(8'h50, 16'h0000, "unmapped");
      chk("hit", 16'h0000, {15'h0000, hit});
      $display("test access_masks done");
      for (int s = 0; s < 2; s++) begin
         oa = 16'($random(seed)) & OC_WARN_MASK;
         host.put(CMD_OC_WARN, oa);
         for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            scale <= s[0];
            iout <= 12'(oa * (s + 1) + e);
            @(posedge clk);
            #1;
            chk("warn", {7'h00, e[0], 2'b00, e[0], 5'h00},
                {7'h00, warn, stat});
         end
      end
      $display("test current_warning done");
      for (int r = 0; r < 4; r++) begin
         oa = 16'($random(seed));
         if (r == 0)
            oa[4:0] = host.ofs_code(1, 5, 1);
         ob = 16'($random(seed));
         host.put(CMD_OFS_A, oa);
         host.put(CMD_OFS_B, ob);
         of = '{5'h00, oa[4:0], oa[9:5], oa[14:10], ob[4:0], ob[9:5]};
         @(posedge clk);
         foreach (pin[k])
            pin[k] <= (r == 1) ? 12'h000 : (r == 2) ? 12'hFFF
                    : (r == 0) ? 12'($random(seed)) & 12'h03F
                                : 12'($random(seed));
         @(posedge clk);
         #1;
         foreach (pin[k])
            chk("phase", {4'h0, ph(pin[k], of[k])},
                {4'h0, pout[k]});
      end
      $display("test phase_offsets done");
      // A reset in mid-run must bring back the documented reset words.
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(CMD_APP_CODE, APP_CODE_RST, "code_rerun");
      rdchk(CMD_CFG_REV, CFG_REV_RST, "rev_rerun");
      rdchk(CMD_OFS_A, OFS_RST, "ofs_rerun");
      $display("test mid_reset done");
      close_out();
   end
endmodule
